// file: verilog/timer_unit_pkg.sv
// Purpose: Constants shared by the free-running capture/compare timer.
// Assumes: APB byte addresses, one aligned 32-bit word per register.
// Notes: Control registers are eight bits wide and sit in the low lanes.
`default_nettype none
package timer_unit_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTL0 = 8'h00;
    localparam logic [7:0] OFF_CTL1 = 8'h04;
    localparam logic [7:0] OFF_OUTCTL = 8'h08;
    localparam logic [7:0] OFF_EDGE = 8'h0c;
    localparam logic [7:0] OFF_OPTION = 8'h10;
    localparam logic [7:0] OFF_OVFCLR = 8'h14;
    localparam logic [7:0] OFF_COUNT = 8'h18;
    localparam logic [7:0] OFF_CC0 = 8'h20;
    localparam logic [7:0] OFF_CC1 = 8'h24;
    localparam logic [7:0] OFF_CC3 = 8'h2c;
    // Field positions.
    localparam int CE_BIT = 7;
    localparam int EEE_BIT = 5;
    localparam int CCS_LSB = 4;
    localparam int OVF_BIT = 0;
    // Operating modes.
    localparam logic [2:0] MODE_PWM = 3'b100;
    localparam logic [2:0] MODE_FREE = 3'b101;
    // Reset values and counter limits.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_CC = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // Valid capture edge per input.
    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_type;
endpackage : timer_unit_pkg
`default_nettype wire

// file: verilog/free_running_capture_compare_timer.sv
// Purpose: 16-bit timer with free-running and PWM modes behind APB.
// Assumes: One clock; pins are asynchronous and pass three flip-flops.
// Notes: Rule summary follows.
// Contract
// - PWM duty zero keeps the channel output inactive all period.
// - PWM period FFFFH with duty zero still raises a match every period.
// - PWM duty equal to period plus one keeps output active all period.
// - Period FFFFH cannot reach 100 percent; the value needs 17 bits.
// - PWM channel match fires as the counter reaches the duty value.
// - Other compare matches fire on the step after the counter equals.
// - Mode 101 selects free running; count enable starts counting.
// - Per-channel option bit picks compare or capture use.
// - Starting free-running count inverts all four output states.
// - Free compare match raises channel interrupt and toggles its pin.
// - After FFFFH the counter overflows, wraps to zero, keeps counting.
// - Overflow sets a sticky flag that software clears.
// - Channel writes are compared immediately in free-running mode.
// - Valid capture edge latches count and raises channel interrupt.
// - Each capture input has its own two-bit edge selection.
// - External event enable counts event edges, ignoring clock select.
// - Each output has enable and disabled-level bits.
// - Count enable zero stops counting, one permits it.
// - PWM period is period value plus one, width is duty value.
// - Clear by bit-clear or option write bit 0 zero; set wins.
`timescale 1ns/1ps
`default_nettype none
module free_running_capture_compare_timer (
    input wire logic pclk, // APB clock, 10 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB write direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data, registered.
    output logic pready, // Always ready.
    output logic pslverr, // Unmapped address error.
    input wire logic [3:0] capture_in_pin, // Capture inputs.
    input wire logic ext_event_pin, // External event count input.
    output logic [3:0] timer_out_pin, // Timer outputs, registered.
    output logic [3:0] channel_cc_irq, // Channel pulses, registered.
    output logic overflow_irq // Overflow pulse, registered.
);
    logic [7:0] ctl0, ctl1, out_ctl, edge_ctl, opt_hi;
    logic ovf, ce_d, pend;
    logic [7:0] pre;
    logic [15:0] cnt, next_cnt;
    logic [15:0] ccr [4];
    logic [15:0] buf_reg [4];
    logic [15:0] eff [4];
    logic [3:0] out_st;
    logic [4:0] s1, s2, s3, stab, rise, fall;
    logic [3:0] cap_hit;
    logic wr, rd_setup, mapped, start, free_on, pwm_on, tick, pwm_clear;
    logic int_tick, wrap, ovf_clr;
    logic [3:0] flip;

    // Decode a register address into a mapped flag.
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= timer_unit_pkg::OFF_COUNT && a[1:0] == 2'b00) ||
            (a >= timer_unit_pkg::OFF_CC0 && a <= timer_unit_pkg::OFF_CC3 && a[1:0] == 2'b00);
    endfunction : is_mapped

    // Decide whether the selected edge occurred on a capture input.
    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        case (timer_unit_pkg::edge_sel_type'(sel))
            timer_unit_pkg::EDGE_NONE: edge_hit = 1'b0;
            timer_unit_pkg::EDGE_RISE: edge_hit = r;
            timer_unit_pkg::EDGE_FALL: edge_hit = f;
            timer_unit_pkg::EDGE_BOTH: edge_hit = r | f;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // The slave never stalls; only the error flag depends on the address.
    assign pready = 1'b1;
    assign mapped = is_mapped(paddr);
    assign pslverr = psel & penable & ~mapped;
    assign wr = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;

    // Mode decode and run qualification.
    assign free_on = ctl0[timer_unit_pkg::CE_BIT] && ctl1[2:0] == timer_unit_pkg::MODE_FREE;
    assign pwm_on = ctl0[timer_unit_pkg::CE_BIT] && ctl1[2:0] == timer_unit_pkg::MODE_PWM;
    assign start = ctl0[timer_unit_pkg::CE_BIT] & ~ce_d;

    // Internal prescaler divides by two to the power of clock select.
    assign int_tick = (pre & ((8'h01 << ctl0[2:0]) - 8'h01)) == ((8'h01 << ctl0[2:0]) - 8'h01);
    assign tick = (free_on | pwm_on) & ~start &
        (ctl1[timer_unit_pkg::EEE_BIT] ? rise[4] : int_tick);
    assign pwm_clear = pwm_on && tick && cnt == buf_reg[0];
    assign wrap = free_on && tick && cnt == timer_unit_pkg::CNT_MAX;
    assign ovf_clr = wr && ((paddr == timer_unit_pkg::OFF_OPTION && !pwdata[timer_unit_pkg::OVF_BIT]) ||
        (paddr == timer_unit_pkg::OFF_OVFCLR && pwdata[timer_unit_pkg::OVF_BIT]));

    // Buffer values as they will stand after this edge, so pins and
    // interrupts use the duty that takes effect with the counter clear.
    always_comb begin
        for (int m = 0; m < 4; m++) begin
            eff[m] = (start || (pwm_clear && pend)) ? ccr[m] : buf_reg[m];
        end
    end

    // Next count: zero at start, step by one, PWM clears at the period.
    always_comb begin
        next_cnt = cnt;
        if (start) begin
            next_cnt = timer_unit_pkg::RST_CC;
        end else if (pwm_clear) begin
            next_cnt = timer_unit_pkg::RST_CC;
        end else if (tick) begin
            next_cnt = cnt + timer_unit_pkg::CNT_ONE;
        end
    end

    // Output states that toggle at this edge. The pin register applies
    // the toggle at once, so a pin change lines up with its interrupt
    // pulse instead of trailing it by one clock.
    always_comb begin
        for (int m = 0; m < 4; m++) begin
            flip[m] = (start && free_on) ||
                (free_on && !opt_hi[m] && tick && cnt == ccr[m]) ||
                (pwm_on && m == 0 && pwm_clear);
        end
    end

    // Capture edge qualification per input.
    always_comb begin
        for (int m = 0; m < 4; m++) begin
            cap_hit[m] = free_on && opt_hi[m] && edge_hit(edge_ctl[2*m +: 2], rise[m], fall[m]);
        end
    end

    // Pin synchronisers: a level counts once stages two and three agree.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 5'h00;
            s2 <= 5'h00;
            s3 <= 5'h00;
            stab <= 5'h00;
            rise <= 5'h00;
            fall <= 5'h00;
        end else begin
            s1 <= {ext_event_pin, capture_in_pin};
            s2 <= s1;
            s3 <= s2;
            stab <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & stab);
            rise <= ~stab & s2 & s3;
            fall <= stab & ~(s2 | s3);
        end
    end

    // Control registers written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0 <= timer_unit_pkg::RST_CTRL;
            ctl1 <= timer_unit_pkg::RST_CTRL;
            out_ctl <= timer_unit_pkg::RST_CTRL;
            edge_ctl <= timer_unit_pkg::RST_CTRL;
            opt_hi <= timer_unit_pkg::RST_CTRL;
        end else if (wr) begin
            case (paddr)
                timer_unit_pkg::OFF_CTL0: ctl0 <= {pwdata[7], 4'h0, pwdata[2:0]};
                timer_unit_pkg::OFF_CTL1: ctl1 <= {1'b0, pwdata[6:5], 2'b00, pwdata[2:0]};
                timer_unit_pkg::OFF_OUTCTL: out_ctl <= pwdata[7:0];
                timer_unit_pkg::OFF_EDGE: edge_ctl <= pwdata[7:0];
                timer_unit_pkg::OFF_OPTION: opt_hi <= {4'h0, pwdata[7:4]};
                default: opt_hi <= opt_hi;
            endcase
        end
    end

    // Prescaler and start detection run on every edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= 8'h00;
            ce_d <= 1'b0;
        end else begin
            pre <= pre + 8'h01;
            ce_d <= ctl0[timer_unit_pkg::CE_BIT];
        end
    end

    // Counter and overflow; the set wins over any clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= timer_unit_pkg::RST_CC;
            ovf <= 1'b0;
            overflow_irq <= 1'b0;
        end else begin
            cnt <= next_cnt;
            overflow_irq <= wrap;
            if (wrap) begin
                ovf <= 1'b1;
            end else if (ovf_clr) begin
                ovf <= 1'b0;
            end
        end
    end

    // Channel registers: capture beats a software write in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int m = 0; m < 4; m++) begin
                ccr[m] <= timer_unit_pkg::RST_CC;
                buf_reg[m] <= timer_unit_pkg::RST_CC;
            end
            pend <= 1'b0;
        end else begin
            for (int m = 0; m < 4; m++) begin
                buf_reg[m] <= eff[m];
                if (cap_hit[m]) begin
                    ccr[m] <= cnt;
                end else if (wr && paddr == timer_unit_pkg::OFF_CC0 + 8'(4 * m)) begin
                    ccr[m] <= pwdata[15:0];
                end
            end
            // A write to channel one arms the transfer at the next clear.
            if (wr && paddr == timer_unit_pkg::OFF_CC0 + 8'h04) begin
                pend <= 1'b1;
            end else if (pwm_clear || start) begin
                pend <= 1'b0;
            end
        end
    end

    // Channel events and output states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_st <= 4'h0;
            channel_cc_irq <= 4'h0;
        end else begin
            for (int m = 0; m < 4; m++) begin
                channel_cc_irq[m] <= 1'b0;
                if (start) begin
                    out_st[m] <= free_on ? ~out_st[m] : 1'b0;
                end else if (free_on && !opt_hi[m]) begin
                    // Compare uses the live register, so a rewrite counts at once.
                    if (tick && cnt == ccr[m]) begin
                        channel_cc_irq[m] <= 1'b1;
                        out_st[m] <= ~out_st[m];
                    end
                end else if (free_on) begin
                    channel_cc_irq[m] <= cap_hit[m];
                end else if (pwm_on && m == 0) begin
                    // Channel zero marks the period on the step after its match.
                    if (pwm_clear) begin
                        channel_cc_irq[m] <= 1'b1;
                        out_st[m] <= ~out_st[m];
                    end
                end else if (pwm_on) begin
                    // Duty zero still matches when the counter returns to zero.
                    channel_cc_irq[m] <= tick && next_cnt == eff[m];
                end
            end
        end
    end

    // Output pins: disabled pins show their level bit; in PWM the level
    // bit of channels one to three selects active-low output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_out_pin <= 4'h0;
        end else begin
            for (int m = 0; m < 4; m++) begin
                if (!out_ctl[2*m]) begin
                    timer_out_pin[m] <= out_ctl[2*m+1];
                end else if (pwm_on && m != 0) begin
                    // A 16-bit duty cannot exceed FFFFH, so period FFFFH never stays on.
                    timer_out_pin[m] <= (next_cnt < eff[m]) ^ out_ctl[2*m+1];
                end else begin
                    timer_out_pin[m] <= out_st[m] ^ flip[m];
                end
            end
        end
    end

    // Read data is captured in the setup cycle and held for the access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                timer_unit_pkg::OFF_CTL0: prdata <= {24'h000000, ctl0};
                timer_unit_pkg::OFF_CTL1: prdata <= {24'h000000, ctl1};
                timer_unit_pkg::OFF_OUTCTL: prdata <= {24'h000000, out_ctl};
                timer_unit_pkg::OFF_EDGE: prdata <= {24'h000000, edge_ctl};
                timer_unit_pkg::OFF_OPTION: prdata <= {24'h000000, opt_hi[3:0], 3'b000, ovf};
                timer_unit_pkg::OFF_COUNT: prdata <= {16'h0000, cnt};
                8'h20: prdata <= {16'h0000, ccr[0]};
                8'h24: prdata <= {16'h0000, ccr[1]};
                8'h28: prdata <= {16'h0000, ccr[2]};
                8'h2c: prdata <= {16'h0000, ccr[3]};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks on the documented timing.
    AST_ZERO_DUTY: assert property (@(posedge pclk) disable iff (!presetn)
        (pwm_on && !start && eff[1] == 16'h0000 && out_ctl[2]) |=> timer_out_pin[1] == out_ctl[3])
        else $error("zero duty drove channel one active");
    AST_FULL_DUTY: assert property (@(posedge pclk) disable iff (!presetn)
        (pwm_on && out_ctl[2] && {1'b0, eff[1]} == {1'b0, eff[0]} + 17'h00001)
        |=> timer_out_pin[1] != out_ctl[3])
        else $error("full duty let channel one go inactive");
    AST_PWM_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        (pwm_on && tick && next_cnt == eff[2]) |=> channel_cc_irq[2] && cnt == $past(eff[2]))
        else $error("pwm match not aligned with count");
    AST_FREE_CMP: assert property (@(posedge pclk) disable iff (!presetn)
        (free_on && !start && !opt_hi[1] && tick && cnt == ccr[1])
        |=> channel_cc_irq[1] && out_st[1] != $past(out_st[1]))
        else $error("free compare missed interrupt or toggle");
    AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        (free_on && tick && cnt == 16'hffff) |=> cnt == 16'h0000 && overflow_irq && ovf)
        else $error("overflow wrap wrong");
    AST_OVF_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        (wrap && ovf_clr) |=> ovf)
        else $error("overflow lost against clear");
    AST_OVF_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        (ovf && !ovf_clr) |=> ovf)
        else $error("overflow flag dropped without clear");
    AST_STOPPED: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl0[7] |=> $stable(cnt))
        else $error("counter moved while disabled");
    AST_START_INVERT: assert property (@(posedge pclk) disable iff (!presetn)
        (start && free_on) |=> out_st == ~$past(out_st))
        else $error("start did not invert outputs");
    AST_CAPTURE: assert property (@(posedge pclk) disable iff (!presetn)
        cap_hit[0] |=> ccr[0] == $past(cnt) && channel_cc_irq[0])
        else $error("capture did not latch count");
    AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        (free_on && tick && cnt != 16'hffff) |=> cnt == $past(cnt) + 16'h0001)
        else $error("counter did not step by one");
    AST_EXT_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
        (free_on && !start && ctl1[5] && !rise[4]) |=> $stable(cnt))
        else $error("counter moved without external event");
    // The enabled pin must change in the same edge as the match pulse.
    AST_FREE_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        (free_on && !start && !opt_hi[1] && tick && cnt == ccr[1] && out_ctl[2])
        |=> timer_out_pin[1] != $past(timer_out_pin[1]))
        else $error("compare match did not toggle pin one");
    // A zero duty still yields one match pulse as the counter returns to zero.
    AST_ZERO_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        (pwm_on && tick && next_cnt == 16'h0000 && eff[3] == 16'h0000)
        |=> channel_cc_irq[3])
        else $error("zero duty lost its match pulse");
endmodule : free_running_capture_compare_timer
`default_nettype wire

// file: testbench/pulse_source_model.sv
// Purpose: Far-side model: pulse sources on capture and event inputs, loads on outputs.
// Assumes: Inputs idle low, as if pulled down, and every pulse spans whole pclk cycles.
// Notes: Pulses last several cycles so that the timer's input synchronisers catch them.
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
    input wire logic pclk, // Bench clock that times the pulses.
    output logic [3:0] capture_in_pin, // Waveforms into the capture inputs.
    output logic ext_event_pin, // Pulses into the event count input.
    input wire logic [3:0] timer_out_pin // Timer outputs driving the loads.
);
    logic [3:0] load_level;

    // The loads only follow the pin levels; a slow load would see the same thing.
    always @(posedge pclk) begin
        load_level <= timer_out_pin;
    end

    // Everything idles low between pulses.
    initial begin
        capture_in_pin = 4'h0;
        ext_event_pin = 1'b0;
    end

    // One high pulse of the given width on capture input m.
    task automatic pulse_capture(input int m, input int width);
        @(posedge pclk);
        capture_in_pin[m] <= 1'b1;
        repeat (width) @(posedge pclk);
        capture_in_pin[m] <= 1'b0;
        repeat (width) @(posedge pclk);
    endtask : pulse_capture

    // Event pulses, slow enough that each rising edge is seen on its own.
    task automatic pulse_event(input int count);
        repeat (count) begin
            @(posedge pclk);
            ext_event_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_event_pin <= 1'b0;
            repeat (4) @(posedge pclk);
        end
    endtask : pulse_event
endmodule : pulse_source_model
`default_nettype wire

// file: testbench/tb.sv
// Purpose: Self-checking bench for the free-running capture/compare timer.
// Assumes: Zero-wait APB slave; clock select 0 gives one count per pclk.
// Notes: One full overflow costs 65536 cycles, so only one is waited for.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] capture_in_pin;
    logic ext_event_pin;
    logic [3:0] timer_out_pin;
    logic [3:0] channel_cc_irq;
    logic overflow_irq;
    logic [31:0] rd;
    logic [31:0] c0;
    logic err;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;

    // Clock at 10 MHz.
    always #50 pclk = ~pclk;

    free_running_capture_compare_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_in_pin(capture_in_pin),
        .ext_event_pin(ext_event_pin), .timer_out_pin(timer_out_pin),
        .channel_cc_irq(channel_cc_irq), .overflow_irq(overflow_irq));

    pulse_source_model src (.pclk(pclk), .capture_in_pin(capture_in_pin),
        .ext_event_pin(ext_event_pin), .timer_out_pin(timer_out_pin));

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // A hang is cut short well after the longest sequence should have ended.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    // Bounded wait for a channel pulse; n reports the cycles spent.
    task automatic wait_irq(input int b, input int lim);
        n = 0;
        while (channel_cc_irq[b] !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_irq

    task automatic t_regs();
        apb(1'b0, timer_unit_pkg::OFF_CTL0, 32'h0);
        check(rd, 32'h0);
        check(32'(timer_out_pin), 32'h0);
        apb(1'b1, timer_unit_pkg::OFF_OUTCTL, 32'haa);
        repeat (3) @(posedge pclk);
        check(32'(timer_out_pin), 32'hf);
        apb(1'b1, timer_unit_pkg::OFF_EDGE, 32'hb4);
        apb(1'b0, timer_unit_pkg::OFF_EDGE, 32'h0);
        check(rd, 32'hb4);
        apb(1'b0, 8'h1c, 32'h0);
        check(32'(err), 32'h1);
        $display("test regs done");
    endtask : t_regs

    task automatic t_free();
        apb(1'b1, timer_unit_pkg::OFF_OUTCTL, 32'h55);
        // Park channels one to three far away so the first tick at zero matches none.
        apb(1'b1, timer_unit_pkg::OFF_CC1, 32'h8000);
        apb(1'b1, timer_unit_pkg::OFF_CC3 - 8'h04, 32'h8000);
        apb(1'b1, timer_unit_pkg::OFF_CC3, 32'h8000);
        apb(1'b1, timer_unit_pkg::OFF_CC0, 32'h40);
        apb(1'b1, timer_unit_pkg::OFF_CTL1, 32'(timer_unit_pkg::MODE_FREE));
        apb(1'b1, timer_unit_pkg::OFF_CTL0, 32'h80);
        repeat (3) @(posedge pclk);
        check(32'(timer_out_pin), 32'hf);
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        c0 = rd;
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        check(rd - c0, 32'h3);
        wait_irq(0, 200);
        check(32'(timer_out_pin), 32'he);
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        apb(1'b1, timer_unit_pkg::OFF_CC1, rd + 32'h30);
        wait_irq(1, 200);
        check(32'(n >= 40 && n <= 50), 32'h1);
        check(32'(timer_out_pin), 32'hc);
        apb(1'b1, timer_unit_pkg::OFF_CTL0, 32'h0);
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        c0 = rd;
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        check(rd - c0, 32'h0);
        $display("test free compare done");
    endtask : t_free

    task automatic t_capture_ovf();
        apb(1'b1, timer_unit_pkg::OFF_OPTION, 32'h20);
        apb(1'b1, timer_unit_pkg::OFF_EDGE, 32'h04);
        apb(1'b1, timer_unit_pkg::OFF_CTL0, 32'h80);
        // The capture pulse fires while the source is still busy, so wait alongside it.
        fork
            src.pulse_capture(1, 4);
            wait_irq(1, 20);
        join
        check(32'(n < 20), 32'h1);
        apb(1'b0, timer_unit_pkg::OFF_CC1, 32'h0);
        c0 = rd;
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        check(32'(rd - c0 >= 2 && rd - c0 <= 16), 32'h1);
        src.pulse_capture(2, 4);
        wait_irq(2, 200);
        check(32'(n), 32'd200);
        n = 0;
        while (overflow_irq !== 1'b1 && n < 70000) begin
            @(posedge pclk);
            n++;
        end
        check(32'(n < 70000), 32'h1);
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        check(32'(rd < 32'h10), 32'h1);
        apb(1'b0, timer_unit_pkg::OFF_OPTION, 32'h0);
        check(rd, 32'h21);
        apb(1'b1, timer_unit_pkg::OFF_OPTION, 32'h20);
        apb(1'b0, timer_unit_pkg::OFF_OPTION, 32'h0);
        check(rd, 32'h20);
        $display("test capture and overflow done");
    endtask : t_capture_ovf

    task automatic t_event();
        apb(1'b1, timer_unit_pkg::OFF_CTL1, 32'h20 | 32'(timer_unit_pkg::MODE_FREE));
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        c0 = rd;
        src.pulse_event(3);
        repeat (8) @(posedge pclk);
        apb(1'b0, timer_unit_pkg::OFF_COUNT, 32'h0);
        check(rd - c0, 32'h3);
        $display("test event count done");
    endtask : t_event

    task automatic t_pwm();
        int hi1;
        int hi2;
        int hi3;
        int ir3;
        logic prev1;
        hi1 = 0;
        hi2 = 0;
        hi3 = 0;
        ir3 = 0;
        do_reset();
        apb(1'b1, timer_unit_pkg::OFF_CTL1, 32'(timer_unit_pkg::MODE_PWM));
        apb(1'b1, timer_unit_pkg::OFF_OUTCTL, 32'h54);
        apb(1'b1, timer_unit_pkg::OFF_CC0, 32'h7);
        apb(1'b1, timer_unit_pkg::OFF_CC3 - 8'h04, 32'h8);
        apb(1'b1, timer_unit_pkg::OFF_CC3, 32'h0);
        apb(1'b1, timer_unit_pkg::OFF_CC1, 32'h3);
        apb(1'b1, timer_unit_pkg::OFF_CTL0, 32'h80);
        repeat (20) @(posedge pclk);
        prev1 = timer_out_pin[1];
        // Sixteen cycles are two whole periods of eight counts.
        for (int i = 0; i < 16; i++) begin
            @(posedge pclk);
            hi1 += int'(timer_out_pin[1]);
            hi2 += int'(timer_out_pin[2]);
            hi3 += int'(timer_out_pin[3]);
            ir3 += int'(channel_cc_irq[3]);
            if (channel_cc_irq[1] === 1'b1) begin
                check(32'({prev1, timer_out_pin[1]}), 32'h2);
            end
            prev1 = timer_out_pin[1];
        end
        check(32'(hi1), 32'd6);
        check(32'(hi2), 32'd16);
        check(32'(hi3), 32'd0);
        check(32'(ir3), 32'd2);
        $display("test pwm done");
    endtask : t_pwm

    // Main sequence.
    initial begin
        do_reset();
        t_regs();
        t_free();
        t_capture_ovf();
        t_event();
        t_pwm();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
